/* File: verilog/tpf_map.svh */
// Constants for the triple port queue block: widths, reset values, pin levels
`ifndef TPF_MAP_SVH
`define TPF_MAP_SVH

// Data widths
`define TPF_PORTA_W 36
`define TPF_PORTBC_W 18
`define TPF_HALF_LSB 18

// Queue depth is two to this power
`define TPF_ADDR_W 6

// Reset values of captured settings
`define TPF_BIG_RST 1'b0
`define TPF_FWFT_RST 1'b0

// Select pin level that picks standard timing after master reset
`define TPF_SEL_STD 1'b1

// Port C buffer depth
`define TPF_CBUF_DEPTH 2'h2

`endif

/* File: verilog/tpf_pkg.sv */
// Types shared by the triple port queue block
package tpf_pkg;

  // Which half of a wide word a narrow port is on
  typedef enum logic {
    TPF_HALF_FIRST,
    TPF_HALF_SECOND
  } tpf_half_t;

endpackage

/* File: verilog/tpf_queue.sv */
// One queue: memory, pointers, output stage and almost flags
`timescale 1ns/100ps
`default_nettype none
`include "tpf_map.svh"

module tpf_queue #(
  parameter int DW = `TPF_PORTA_W,
  parameter int AW = `TPF_ADDR_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Control
  input wire logic clr_i,
  input wire logic fwft_i,
  input wire logic [AW:0] ae_off_i,
  input wire logic [AW:0] af_off_i,
  // Write side
  input wire logic wr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic full_o,
  output logic af_n_o,
  // Read side
  input wire logic rd_i,
  output logic [DW-1:0] dout_o,
  output logic dvalid_o,
  output logic ae_n_o
);
  import tpf_pkg::*;

  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] cnt;
    logic [AW:0] ae_off;
    logic [AW:0] af_off;
    logic [DW-1:0] dout;
    logic dvalid;
    logic full;
    logic ae_n;
    logic af_n;
  } tpf_q_state_t;

  tpf_q_state_t q, d;
  logic [DW-1:0] mem [2**AW];
  logic push;
  logic load;
  logic [AW:0] cnt_next;

  always_comb begin
    d = q;
    push = wr_i && !q.full && !clr_i;
    if (fwft_i) begin
      load = (q.cnt != '0) && (!q.dvalid || rd_i) && !clr_i;
    end else begin
      load = rd_i && (q.cnt != '0) && !clr_i;
    end
    cnt_next = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    if (push) begin
      d.wptr = q.wptr + 1'b1;
    end
    if (load) begin
      d.rptr = q.rptr + 1'b1;
      d.dout = mem[q.rptr[AW-1:0]];
    end
    if (fwft_i) begin
      d.dvalid = load | (q.dvalid & ~rd_i);
    end else begin
      d.dvalid = rd_i ? load : q.dvalid;
    end
    d.cnt = cnt_next;
    d.full = (cnt_next == DEPTH);
    d.ae_n = !(cnt_next <= q.ae_off);
    d.af_n = !((DEPTH - cnt_next) <= q.af_off);
    if (clr_i) begin
      d.wptr = '0;
      d.rptr = '0;
      d.cnt = '0;
      d.dvalid = 1'b0;
      d.full = 1'b0;
      d.ae_off = ae_off_i;
      d.af_off = af_off_i;
      d.ae_n = 1'b0;
      d.af_n = !(DEPTH <= af_off_i);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.af_n <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Memory has no reset; only the pointers say what is valid
  always_ff @(posedge clock_i) begin
    if (ce_i && push) begin
      mem[q.wptr[AW-1:0]] <= wdata_i;
    end
  end

  assign full_o = q.full;
  assign af_n_o = q.af_n;
  assign dout_o = q.dout;
  assign dvalid_o = q.dvalid;
  assign ae_n_o = q.ae_n;

  ae_level_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ae_n_o == (q.cnt > q.ae_off)) else $error("almost empty flag disagrees with count");
  af_level_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    af_n_o == ((DEPTH - q.cnt) > q.af_off)) else $error("almost full flag disagrees with free space");
  clr_pointers_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && clr_i |=> q.wptr == '0 && q.rptr == '0 && q.cnt == '0 && q.af_off == $past(af_off_i))
    else $error("master reset did not rewind the queue");
  fall_through_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && fwft_i && !clr_i && !q.dvalid && q.cnt != '0 |=> dvalid_o && q.rptr == $past(q.rptr) + 1'b1)
    else $error("first word did not fall through");
  std_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !fwft_i && !rd_i && !clr_i |=> $stable(dout_o) && $stable(q.rptr))
    else $error("standard mode read without request");
  full_guard_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    q.full && !clr_i |=> q.wptr == $past(q.wptr)) else $error("queue overflowed");

endmodule

`default_nettype wire

/* File: verilog/tpf_top.sv */
// Two queue, three port buffer with almost flags, byte order and timing select
//
// How it works
// - Port A 36 bits, writes AB, reads CA
// - Port B 18 bit output from AB queue
// - Port C 18 bit input into CA queue
// - Port A almost empty low: CA count<=offset
// - Port B almost empty low: AB count<=offset
// - Port A almost full low: AB free<=offset
// - Port C almost full low: CA free<=offset
// - Select high at reset: high half first
// - Select low at reset: low half first
// - After reset select: high standard, low fall-through
// - Fall-through shows first word without read
// - Master reset rewinds pointers, loads flag offsets
`timescale 1ns/100ps
`default_nettype none
`include "tpf_map.svh"

module tpf_top #(
  parameter int AW = `TPF_ADDR_W
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Master resets and select pin
  input wire logic mrs_ab_n_i,
  input wire logic mrs_ca_n_i,
  input wire logic byte_order_timing_sel_i,
  // Flag offsets, taken during master reset
  input wire logic [AW:0] a_almost_empty_offset_i,
  input wire logic [AW:0] b_almost_empty_offset_i,
  input wire logic [AW:0] a_almost_full_offset_i,
  input wire logic [AW:0] c_almost_full_offset_i,
  // Port A
  input wire logic porta_en_i,
  input wire logic porta_write_i,
  input wire logic [`TPF_PORTA_W-1:0] porta_data_i,
  output logic [`TPF_PORTA_W-1:0] porta_data_o,
  output logic porta_data_oe_o,
  output logic porta_full_o,
  output logic porta_out_valid_o,
  output logic porta_almost_empty_n_o,
  output logic porta_almost_full_n_o,
  // Port B
  input wire logic portb_rd_i,
  output logic [`TPF_PORTBC_W-1:0] portb_data_o,
  output logic portb_valid_o,
  output logic portb_almost_empty_n_o,
  // Port C
  input wire logic portc_valid_i,
  input wire logic [`TPF_PORTBC_W-1:0] portc_data_i,
  output logic portc_ready_o,
  output logic portc_almost_full_n_o,
  // Mode
  output logic fwft_mode_o
);
  import tpf_pkg::*;

  localparam int HW = `TPF_PORTBC_W;
  localparam int WW = `TPF_PORTA_W;

  typedef struct packed {
    logic mrs_ab_s1;
    logic mrs_ab_s2;
    logic mrs_ca_s1;
    logic mrs_ca_s2;
    logic sel_s1;
    logic sel_s2;
    logic big_ab;
    logic big_ca;
    logic fwft;
    logic oe;
    tpf_half_t b_half;
    logic [HW-1:0] b_data;
    logic b_valid;
    logic [HW-1:0] buf0;
    logic [HW-1:0] buf1;
    logic [1:0] buf_cnt;
    logic c_ready;
    tpf_half_t c_half;
    logic [HW-1:0] c_hold;
  } tpf_top_state_t;

  tpf_top_state_t q, d;

  logic ab_clr;
  logic ca_clr;
  logic ab_wr;
  logic ab_rd;
  logic ab_full;
  logic [WW-1:0] ab_dout;
  logic ab_dvalid;
  logic ca_wr;
  logic ca_rd;
  logic ca_full;
  logic [WW-1:0] ca_wdata;
  logic b_adv;
  logic c_push;
  logic c_pop;
  logic [1:0] cnt_next;

  ////////////////////////////////////////////////////////////////////////////
  // Queues

  // AB queue always prefetches; port B applies the chosen timing itself
  tpf_queue #(.DW(WW), .AW(AW)) u_ab_queue (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .clr_i(ab_clr),
    .fwft_i(1'b1),
    .ae_off_i(b_almost_empty_offset_i),
    .af_off_i(a_almost_full_offset_i),
    .wr_i(ab_wr),
    .wdata_i(porta_data_i),
    .full_o(ab_full),
    .af_n_o(porta_almost_full_n_o),
    .rd_i(ab_rd),
    .dout_o(ab_dout),
    .dvalid_o(ab_dvalid),
    .ae_n_o(portb_almost_empty_n_o)
  );

  tpf_queue #(.DW(WW), .AW(AW)) u_ca_queue (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .clr_i(ca_clr),
    .fwft_i(q.fwft),
    .ae_off_i(a_almost_empty_offset_i),
    .af_off_i(c_almost_full_offset_i),
    .wr_i(ca_wr),
    .wdata_i(ca_wdata),
    .full_o(ca_full),
    .af_n_o(portc_almost_full_n_o),
    .rd_i(ca_rd),
    .dout_o(porta_data_o),
    .dvalid_o(porta_out_valid_o),
    .ae_n_o(porta_almost_empty_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    // Pins from outside the clock domain
    d.mrs_ab_s1 = mrs_ab_n_i;
    d.mrs_ab_s2 = q.mrs_ab_s1;
    d.mrs_ca_s1 = mrs_ca_n_i;
    d.mrs_ca_s2 = q.mrs_ca_s1;
    d.sel_s1 = byte_order_timing_sel_i;
    d.sel_s2 = q.sel_s1;
    ab_clr = !q.mrs_ab_s2;
    ca_clr = !q.mrs_ca_s2;

    // Byte order taken in every internal reset cycle; the last one sticks
    if (!q.mrs_ab_s2) begin
      d.big_ab = q.sel_s2;
    end
    if (!q.mrs_ca_s2) begin
      d.big_ca = q.sel_s2;
    end
    // Pin level assumed static once out of reset
    if (q.mrs_ab_s2 && q.mrs_ca_s2) begin
      d.fwft = (q.sel_s2 != `TPF_SEL_STD);
    end

    // Port A
    ab_wr = porta_en_i && porta_write_i && !ab_clr;
    ca_rd = porta_en_i && !porta_write_i && !ca_clr;
    d.oe = !porta_write_i;

    // Port B: two halves per wide word
    b_adv = portb_rd_i || (q.fwft && !q.b_valid);
    ab_rd = 1'b0;
    if (b_adv && ab_dvalid) begin
      if ((q.b_half == TPF_HALF_FIRST) == q.big_ab) begin
        d.b_data = ab_dout[WW-1:`TPF_HALF_LSB];
      end else begin
        d.b_data = ab_dout[HW-1:0];
      end
      d.b_valid = 1'b1;
      if (q.b_half == TPF_HALF_SECOND) begin
        ab_rd = 1'b1;
        d.b_half = TPF_HALF_FIRST;
      end else begin
        d.b_half = TPF_HALF_SECOND;
      end
    end else if (portb_rd_i) begin
      d.b_valid = 1'b0;
    end

    // Port C: two entry buffer, then pairing into wide words
    c_push = portc_valid_i && q.c_ready;
    ca_wr = (q.buf_cnt != 2'h0) && (q.c_half == TPF_HALF_SECOND) && !ca_full && !ca_clr;
    c_pop = (q.buf_cnt != 2'h0) && ((q.c_half == TPF_HALF_FIRST) || ca_wr) && !ca_clr;
    if (q.big_ca) begin
      ca_wdata = {q.c_hold, q.buf0};
    end else begin
      ca_wdata = {q.buf0, q.c_hold};
    end
    if (c_pop) begin
      if (q.c_half == TPF_HALF_FIRST) begin
        d.c_hold = q.buf0;
        d.c_half = TPF_HALF_SECOND;
      end else begin
        d.c_half = TPF_HALF_FIRST;
      end
    end
    cnt_next = q.buf_cnt;
    case ({c_push, c_pop})
      2'b10: begin
        if (q.buf_cnt == 2'h0) begin
          d.buf0 = portc_data_i;
        end else begin
          d.buf1 = portc_data_i;
        end
        cnt_next = q.buf_cnt + 2'h1;
      end
      2'b01: begin
        d.buf0 = q.buf1;
        cnt_next = q.buf_cnt - 2'h1;
      end
      2'b11: begin
        if (q.buf_cnt == 2'h1) begin
          d.buf0 = portc_data_i;
        end else begin
          d.buf0 = q.buf1;
          d.buf1 = portc_data_i;
        end
      end
      default: begin
        cnt_next = q.buf_cnt;
      end
    endcase
    d.buf_cnt = cnt_next;
    d.c_ready = (cnt_next < `TPF_CBUF_DEPTH);

    // Master reset empties the narrow port paths as well
    if (ab_clr) begin
      d.b_half = TPF_HALF_FIRST;
      d.b_valid = 1'b0;
    end
    if (ca_clr) begin
      d.c_half = TPF_HALF_FIRST;
      d.buf_cnt = 2'h0;
      d.c_ready = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.big_ab <= `TPF_BIG_RST;
      q.big_ca <= `TPF_BIG_RST;
      q.fwft <= `TPF_FWFT_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign porta_data_oe_o = q.oe;
  assign porta_full_o = ab_full;
  assign portb_data_o = q.b_data;
  assign portb_valid_o = q.b_valid;
  assign portc_ready_o = q.c_ready;
  assign fwft_mode_o = q.fwft;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  order_capture_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && !q.mrs_ab_s2 |=> q.big_ab == $past(q.sel_s2))
    else $error("byte order not taken at reset release");
  order_frozen_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    q.mrs_ca_s2 && $past(q.mrs_ca_s2) |-> $stable(q.big_ca))
    else $error("byte order changed outside master reset");
  mode_select_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && q.mrs_ab_s2 && q.mrs_ca_s2 |=> fwft_mode_o == ($past(q.sel_s2) != `TPF_SEL_STD))
    else $error("timing mode does not follow select pin");
  port_dir_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i |=> porta_data_oe_o == !$past(porta_write_i)) else $error("port A drive direction wrong");
  b_first_half_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && b_adv && ab_dvalid && !ab_clr && q.b_half == TPF_HALF_FIRST |=>
    portb_data_o == ($past(q.big_ab) ? $past(ab_dout[WW-1:`TPF_HALF_LSB]) : $past(ab_dout[HW-1:0])))
    else $error("port B first half in wrong order");
  b_fall_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && q.fwft && !q.b_valid && ab_dvalid && !ab_clr |=> portb_valid_o)
    else $error("port B word did not fall through");
  c_pairing_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ca_wr && q.big_ca |-> ca_wdata[WW-1:`TPF_HALF_LSB] == q.c_hold)
    else $error("port C first word not in high half");
  buf_bound_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    q.buf_cnt <= `TPF_CBUF_DEPTH && (q.buf_cnt != `TPF_CBUF_DEPTH || !portc_ready_o))
    else $error("port C buffer overrun");

  b_fall_c: cover property (@(posedge clock_i) disable iff (!rstn_i) q.fwft && !q.b_valid ##1 portb_valid_o);
  buf_full_c: cover property (@(posedge clock_i) disable iff (!rstn_i) q.buf_cnt == `TPF_CBUF_DEPTH);
  c_write_c: cover property (@(posedge clock_i) disable iff (!rstn_i) ca_wr && q.big_ca);
  ab_full_c: cover property (@(posedge clock_i) disable iff (!rstn_i) ab_full);

endmodule

`default_nettype wire

/* File: testbench/tpf_portc_src.sv */
// Port C sender model: offers queued halves until taken
`timescale 1ns/100ps
`default_nettype none

module tpf_portc_src (
  // Clock
  input wire logic clock_i,
  // Pacing
  input wire logic slow_i,
  // Port C
  input wire logic ready_i,
  output logic valid_o,
  output logic [17:0] data_o
);
  logic [17:0] q[$];
  logic taken;
  logic gap;

  initial begin
    valid_o = 1'b0;
    data_o = 18'h0;
    taken = 1'b0;
    gap = 1'b0;
  end

  task automatic push(input logic [17:0] w);
    q.push_back(w);
  endtask

  always @(posedge clock_i) begin
    taken <= valid_o && ready_i;
  end

  ////////////////////////////////////////////////////////////
  // Offer held until taken; idle data keeps changing
  always @(negedge clock_i) begin
    if (taken) begin
      void'(q.pop_front());
    end
    gap = taken && slow_i;
    if (q.size() != 0 && !gap) begin
      valid_o <= 1'b1;
      data_o <= q[0];
    end
    else begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule

`default_nettype wire

/* File: testbench/tb_tpf_top.sv */
// Self-checking bench for the triple port queue block
`timescale 1ns/100ps
`default_nettype none

module tb_tpf_top;
  logic clock_i, rstn_i, mab_n, mca_n, sel, slow;
  logic [6:0] aae, bae, aaf, caf;
  logic aen, awr, brd, cval, aoe, afull, aval, aae_n, aaf_n;
  logic bval, bae_n, crdy, caf_n, fwft;
  logic [35:0] adi, ado;
  logic [17:0] bdo, cdi;
  logic [35:0] wa[3];
  int bad_count, samples_checked;

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  tpf_top dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .mrs_ab_n_i(mab_n), .mrs_ca_n_i(mca_n), .byte_order_timing_sel_i(sel),
    .a_almost_empty_offset_i(aae), .b_almost_empty_offset_i(bae),
    .a_almost_full_offset_i(aaf), .c_almost_full_offset_i(caf),
    .porta_en_i(aen), .porta_write_i(awr), .porta_data_i(adi),
    .porta_data_o(ado), .porta_data_oe_o(aoe), .porta_full_o(afull),
    .porta_out_valid_o(aval), .porta_almost_empty_n_o(aae_n),
    .porta_almost_full_n_o(aaf_n), .portb_rd_i(brd), .portb_data_o(bdo),
    .portb_valid_o(bval), .portb_almost_empty_n_o(bae_n),
    .portc_valid_i(cval), .portc_data_i(cdi), .portc_ready_o(crdy),
    .portc_almost_full_n_o(caf_n), .fwft_mode_o(fwft)
  );

  tpf_portc_src part_u (
    .clock_i(clock_i), .slow_i(slow), .ready_i(crdy),
    .valid_o(cval), .data_o(cdi)
  );

  ////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t data %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end
    else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Port access
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic mreset(input logic o, input logic [6:0] x0, x1, y0, y1);
    mab_n = 1'b0;
    mca_n = 1'b0;
    sel = o;
    aae = x0;
    bae = x1;
    aaf = y0;
    caf = y1;
    cyc(6);
    mab_n = 1'b1;
    mca_n = 1'b1;
    cyc(5);
  endtask

  task automatic a_write(input logic [35:0] w);
    aen = 1'b1;
    awr = 1'b1;
    adi = w;
    cyc(1);
    aen = 1'b0;
    adi = ~w;
    chk_flag(aoe, 1'b0);
    cyc(1);
  endtask

  task automatic a_read;
    aen = 1'b1;
    awr = 1'b0;
    cyc(1);
    aen = 1'b0;
    cyc(1);
    chk_flag(aoe, 1'b1);
  endtask

  task automatic b_read;
    brd = 1'b1;
    cyc(1);
    brd = 1'b0;
    cyc(1);
  endtask

  task automatic b_chk(input logic [17:0] e);
    chk_flag(bval, 1'b1);
    chk_word({18'h0, bdo}, {18'h0, e});
  endtask

  function automatic logic [17:0] hv(input int k);
    return 18'(k * 5 + 3);
  endfunction

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bad_count = 0;
    samples_checked = 0;
    {rstn_i, sel, slow, aen, awr, brd, aae, bae, aaf, caf} = '0;
    {mab_n, mca_n} = 2'h3;
    adi = 36'h0;
    wa = '{36'h9abcd1234, 36'h13579bdf0, 36'h2468ace11};
    cyc(16);
    chk_flag(aaf_n, 1'b1);
    chk_flag(caf_n, 1'b1);
    rstn_i = 1'b1;
    cyc(2);
    // High half first, then fall-through
    mreset(1'b1, 7'h1, 7'h1, 7'h3e, 7'h3e);
    sel = 1'b0;
    cyc(4);
    chk_flag(fwft, 1'b1);
    for (int i = 0; i < 3; i++) begin
      a_write(wa[i]);
    end
    cyc(4);
    b_chk(wa[0][35:18]);
    b_read;
    b_chk(wa[0][17:0]);
    b_read;
    b_chk(wa[1][35:18]);
    slow = 1'b1;
    part_u.push(18'h16971);
    part_u.push(18'h0c3a5);
    for (int n = 0; n < 100 && aval !== 1'b1; n++) begin
      cyc(1);
    end
    if (aval !== 1'b1) begin
      $display("[FAIL] %0t port A word never fell through", $time);
      bad_count++;
      close_out;
    end
    chk_word(ado, {18'h16971, 18'h0c3a5});
    a_read;
    chk_flag(aval, 1'b0);
    // Low half first, standard timing
    mreset(1'b0, 7'h0, 7'h0, 7'h3e, 7'h3e);
    sel = 1'b1;
    cyc(4);
    chk_flag(fwft, 1'b0);
    chk_flag(bval, 1'b0);
    a_write(wa[0]);
    cyc(1);
    chk_flag(bae_n, 1'b0);
    a_write(wa[1]);
    cyc(1);
    chk_flag(bae_n, 1'b1);
    chk_flag(aaf_n, 1'b1);
    a_write(wa[2]);
    cyc(1);
    chk_flag(aaf_n, 1'b0);
    chk_flag(afull, 1'b0);
    chk_flag(bval, 1'b0);
    for (int i = 0; i < 3; i++) begin
      b_read;
      b_chk(wa[i][17:0]);
      b_read;
      b_chk(wa[i][35:18]);
      cyc(1);
      chk_flag(aaf_n, 1'b1);
    end
    chk_flag(bae_n, 1'b0);
    b_read;
    chk_flag(bval, 1'b0);
    // Fill the C to A queue until port C refuses
    slow = 1'b0;
    for (int k = 0; k < 131; k++) begin
      part_u.push(hv(k));
    end
    cyc(170);
    chk_flag(crdy, 1'b0);
    chk_flag(caf_n, 1'b0);
    chk_flag(aae_n, 1'b1);
    chk_flag(aval, 1'b0);
    for (int j = 0; j < 65; j++) begin
      a_read;
      chk_flag(aval, 1'b1);
      chk_word(ado, {hv(2 * j + 1), hv(2 * j)});
    end
    a_read;
    chk_flag(aval, 1'b0);
    chk_flag(aae_n, 1'b0);
    chk_flag(caf_n, 1'b1);
    close_out;
  end
endmodule

`default_nettype wire
